// ===== rg_ccd_pkg.sv
// constants for the resistive-gate linear sensor charge model
// assumes one 32-bit AXI4-Lite slave, word-aligned registers
package rg_ccd_pkg;
   localparam int CHARGE_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 32;
   localparam int LINE_W = 16;
   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_PHOTO_RATE = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_FULL_WELL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_INTEG = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_LINES = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_DRAIN = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_LAST_PIX = 8'h14;
   // reset values and charge ceiling
   localparam logic [CHARGE_W-1:0] PHOTO_RATE_RST = 16'h0010;
   localparam logic [CHARGE_W-1:0] FULL_WELL_RST = 16'h8000;
   localparam logic [CHARGE_W-1:0] CHARGE_MAX = 16'hFFFF;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rg_ccd_pkg

// ===== rg_ccd_sensor.sv
// charge model of a resistive-gate linear sensor behind its gate pins
// assumes the timing generator drives gates and pix_clk_in; AXI on sys_clk
`timescale 1ns/100ps
`default_nettype none
module rg_ccd_sensor
   import rg_ccd_pkg::*;
#(
   parameter int PIXELS = 8
) (
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // gate pins from the timing generator
   input wire logic pix_clk_in,
   input wire logic overflow_reset_gate_in,
   input wire logic store_to_shift_gate_in,
   input wire logic shift_phase_one_in,
   input wire logic shift_phase_two_in,
   input wire logic slope_gate_upper_end_in,
   input wire logic slope_gate_lower_end_in,
   // video output, pixel clock domain
   output logic [CHARGE_W-1:0] video_output_out,
   output logic video_valid_out,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [DATA_W-1:0] s_axi_wdata_in,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);

   function automatic logic [CHARGE_W-1:0] sat_add(
      input logic [CHARGE_W-1:0] a,
      input logic [CHARGE_W-1:0] b,
      input logic [CHARGE_W-1:0] lim);
      logic [CHARGE_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[CHARGE_W-1:0];
   endfunction : sat_add

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] nw,
      input logic [DATA_W/8-1:0] strb);
      merge = old;
      for (int i = 0; i < DATA_W / 8; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction : merge

   // system-domain registers
   logic [CHARGE_W-1:0] photo_rate;
   logic [CHARGE_W-1:0] full_well;
   logic cfg_tgl;
   logic aw_hold, w_hold;
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [DATA_W/8-1:0] w_strb;
   logic [CNT_W-1:0] sys_integ, sys_drain;
   logic [LINE_W-1:0] sys_lines;
   logic [CHARGE_W-1:0] sys_last_pix;
   logic [2:0] snap_sync;
   logic [1:0] ack_sync;

   // link-domain state
   logic rst_m, link_rst;
   logic [1:0] org_p, tg_p, p1_p, p2_p, up_p, lo_p;
   logic tg_q, org_q, p1_q;
   logic [2:0] cfg_sync;
   logic [CHARGE_W-1:0] rate_l, well_l;
   logic [CHARGE_W-1:0] slope_q, store, xfer;
   logic [CHARGE_W-1:0] hreg [PIXELS];
   logic [CNT_W-1:0] integ, drained;
   logic [CNT_W-1:0] snap_integ, snap_drain;
   logic [LINE_W-1:0] lines;
   logic [CHARGE_W-1:0] last_pix;
   logic snap_tgl;

   // link reset follows the system reset through two flops
   always_ff @(posedge pix_clk_in) begin
      rst_m <= sys_rst_in;
      link_rst <= rst_m;
   end

   // gate pins pass two flops before any logic
   always_ff @(posedge pix_clk_in) begin
      org_p <= {org_p[0], overflow_reset_gate_in};
      tg_p <= {tg_p[0], store_to_shift_gate_in};
      p1_p <= {p1_p[0], shift_phase_one_in};
      p2_p <= {p2_p[0], shift_phase_two_in};
      up_p <= {up_p[0], slope_gate_upper_end_in};
      lo_p <= {lo_p[0], slope_gate_lower_end_in};
   end

   wire org_s = org_p[1];
   wire tg_s = tg_p[1];
   wire p1_s = p1_p[1];
   wire p2_s = p2_p[1];
   wire tg_fall = tg_q && !tg_s;
   wire org_fall = org_q && !org_s;
   wire shift_pulse = p1_s && !p1_q && !p2_s;
   wire cfg_edge = cfg_sync[2] ^ cfg_sync[1];

   wire slope_on = up_p[1] != lo_p[1];
   wire [CHARGE_W-1:0] slope_acc = sat_add(slope_q, rate_l, CHARGE_MAX);
   wire [CHARGE_W-1:0] inflow = slope_on ? slope_acc : '0;
   wire [CHARGE_W:0] store_sum = {1'b0, store} + {1'b0, inflow};
   wire over = store_sum > {1'b0, well_l};
   // closed shutter wins over the transfer gate: nothing reaches output
   wire [CNT_W-1:0] drain_add = org_s ? CNT_W'(store_sum) :
      tg_s ? '0 :
      over ? CNT_W'(store_sum - {1'b0, well_l}) : '0;

   always_ff @(posedge pix_clk_in) begin
      if (link_rst) begin
         tg_q <= 1'b0;
         org_q <= 1'b0;
         p1_q <= 1'b0;
         cfg_sync <= '0;
         rate_l <= PHOTO_RATE_RST;
         well_l <= FULL_WELL_RST;
      end else begin
         tg_q <= tg_s;
         org_q <= org_s;
         p1_q <= p1_s;
         cfg_sync <= {cfg_sync[1:0], cfg_tgl};
         // config words are held still while the toggle crosses
         if (cfg_edge) begin
            rate_l <= photo_rate;
            well_l <= full_well;
         end
      end
   end

   // charge flow: slope gate, storage, transfer gate
   always_ff @(posedge pix_clk_in) begin
      if (link_rst) begin
         slope_q <= '0;
         store <= '0;
         xfer <= '0;
         drained <= '0;
      end else begin
         // pinned ends hold charge in the slope gate
         slope_q <= slope_on ? '0 : slope_acc;
         drained <= drained + drain_add;
         if (tg_s) begin
            // storage empties into the transfer gate
            // no integration window while the shutter is closed
            if (!org_s) begin
               xfer <= sat_add(xfer, sat_add(store, inflow, CHARGE_MAX),
                               CHARGE_MAX);
            end
            store <= '0;
         end else begin
            if (tg_fall) begin
               xfer <= '0;
            end
            if (org_s) begin
               store <= '0;
            end else if (over) begin
               store <= well_l;
            end else begin
               store <= store_sum[CHARGE_W-1:0];
            end
         end
      end
   end

   // horizontal register and video output
   always_ff @(posedge pix_clk_in) begin
      if (link_rst) begin
         hreg <= '{default: '0};
         video_output_out <= '0;
         video_valid_out <= 1'b0;
      end else begin
         video_valid_out <= shift_pulse;
         if (tg_fall) begin
            // falling transfer gate loads every pixel
            hreg <= '{default: xfer};
         end else if (shift_pulse) begin
            video_output_out <= hreg[PIXELS-1];
            for (int i = PIXELS - 1; i > 0; i--) begin
               hreg[i] <= hreg[i-1];
            end
            hreg[0] <= '0;
         end
      end
   end

   always_ff @(posedge pix_clk_in) begin
      if (link_rst) begin
         integ <= '0;
         snap_integ <= '0;
         snap_drain <= '0;
         lines <= '0;
         last_pix <= '0;
         snap_tgl <= 1'b0;
      end else begin
         integ <= (org_fall || tg_fall) ? '0 : integ + 1'b1;
         if (tg_fall) begin
            // count includes the transfer-fall cycle itself
            snap_integ <= integ + 1'b1;
            snap_drain <= drained;
            lines <= lines + 1'b1;
            last_pix <= xfer;
            snap_tgl <= !snap_tgl;
         end
      end
   end

   // snapshot crosses by toggle; words are stable for a whole line
   wire snap_edge = snap_sync[2] ^ snap_sync[1];
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         snap_sync <= '0;
         ack_sync <= '0;
         sys_integ <= '0;
         sys_drain <= '0;
         sys_lines <= '0;
         sys_last_pix <= '0;
      end else begin
         snap_sync <= {snap_sync[1:0], snap_tgl};
         ack_sync <= {ack_sync[0], cfg_sync[2]};
         if (snap_edge) begin
            sys_integ <= snap_integ;
            sys_drain <= snap_drain;
            sys_lines <= lines;
            sys_last_pix <= last_pix;
         end
      end
   end

   // AXI4-Lite write path, address and data in either order
   // config words must not change until the link side has taken them
   wire cfg_busy = cfg_tgl != ack_sync[1];
   assign s_axi_awready_out = !aw_hold && !s_axi_bvalid_out && !cfg_busy;
   assign s_axi_wready_out = !w_hold && !s_axi_bvalid_out && !cfg_busy;
   wire do_write = aw_hold && w_hold;
   wire wr_rate = aw_addr == ADDR_PHOTO_RATE;
   wire wr_well = aw_addr == ADDR_FULL_WELL;
   wire [DATA_W-1:0] rate_new = merge(DATA_W'(photo_rate), w_data, w_strb);
   wire [DATA_W-1:0] well_new = merge(DATA_W'(full_well), w_data, w_strb);

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
         photo_rate <= PHOTO_RATE_RST;
         full_well <= FULL_WELL_RST;
         cfg_tgl <= 1'b0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wr_rate || wr_well) ? RESP_OKAY : RESP_SLVERR;
            if (wr_rate) begin
               photo_rate <= rate_new[CHARGE_W-1:0];
            end
            if (wr_well) begin
               full_well <= well_new[CHARGE_W-1:0];
            end
            if (wr_rate || wr_well) begin
               cfg_tgl <= !cfg_tgl;
            end
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // AXI4-Lite read path
   assign s_axi_arready_out = !s_axi_rvalid_out;
   wire rd_take = s_axi_arvalid_in && s_axi_arready_out;
   wire rd_known = s_axi_araddr_in inside {ADDR_PHOTO_RATE, ADDR_FULL_WELL,
      ADDR_INTEG, ADDR_LINES, ADDR_DRAIN, ADDR_LAST_PIX};
   wire [DATA_W-1:0] rd_mux =
      (s_axi_araddr_in == ADDR_PHOTO_RATE) ? DATA_W'(photo_rate) :
      (s_axi_araddr_in == ADDR_FULL_WELL) ? DATA_W'(full_well) :
      (s_axi_araddr_in == ADDR_INTEG) ? sys_integ :
      (s_axi_araddr_in == ADDR_LINES) ? DATA_W'(sys_lines) :
      (s_axi_araddr_in == ADDR_DRAIN) ? sys_drain :
      (s_axi_araddr_in == ADDR_LAST_PIX) ? DATA_W'(sys_last_pix) : '0;

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_mux;
         s_axi_rresp_out <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // checks on the charge model and the AXI read answer
   sequence tg_falls;
      tg_q && !tg_s;
   endsequence

   store_clear_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      org_s |=> store == '0)
      else $error("storage not drained with shutter closed");
   full_well_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      !tg_s && !org_s && over |=> store == $past(well_l))
      else $error("storage exceeded full well");
   slope_move_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      slope_on |=> slope_q == '0)
      else $error("slope gate kept charge with a slope present");
   no_slope_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      !slope_on && !tg_s && !org_s && !over
      |=> store == $past(store))
      else $error("charge moved without a slope");
   tg_take_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      tg_s |=> store == '0 ##0 xfer >= $past(xfer))
      else $error("transfer gate did not take storage");
   tg_load_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      tg_falls |=> hreg[PIXELS-1] == $past(xfer) ##0 xfer == '0)
      else $error("shift register not loaded at transfer fall");
   shift_hold_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      !shift_pulse && !tg_fall |=> $stable(hreg[PIXELS-1])
         ##0 !video_valid_out)
      else $error("shift register moved without a pulse");
   shift_out_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      shift_pulse && !tg_fall
      |=> video_output_out == $past(hreg[PIXELS-1]) ##0 video_valid_out)
      else $error("video sample differs from last pixel");
   integ_win_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      tg_falls |=> snap_integ == $past(integ) + 1'b1 ##0 integ == '0)
      else $error("integration window not captured");
   drain_out_a: assert property (
      @(posedge pix_clk_in) disable iff (link_rst)
      org_s && !tg_s |=> drained == $past(drained) + $past(drain_add))
      else $error("discarded charge not counted to drain");
   read_ans_a: assert property (
      @(posedge sys_clk_in) disable iff (sys_rst_in)
      rd_take |=> s_axi_rvalid_out && !s_axi_arready_out)
      else $error("read not answered in one cycle");
endmodule : rg_ccd_sensor
`default_nettype wire

// ===== ccd_gate_gen.sv
// timing generator model that drives the sensor gate pins
// assumes a free-running pix_clk; pins change just after its rising edge
`timescale 1ns/100ps
`default_nettype none
module ccd_gate_gen (
   // link clock
   input wire logic pix_clk_in,
   // gate pins
   output logic overflow_reset_gate_out,
   output logic store_to_shift_gate_out,
   output logic shift_phase_one_out,
   output logic shift_phase_two_out,
   output logic slope_gate_upper_end_out,
   output logic slope_gate_lower_end_out,
   // high while readout pixels are due
   output logic reading_out
);
   initial begin
      overflow_reset_gate_out = 1'b0;
      store_to_shift_gate_out = 1'b0;
      shift_phase_one_out = 1'b0;
      shift_phase_two_out = 1'b0;
      slope_gate_upper_end_out = 1'b1;
      slope_gate_lower_end_out = 1'b0;
      reading_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge pix_clk_in);
   endtask : tick

   task automatic set_ends(input logic [1:0] v);
      slope_gate_upper_end_out <= v[1];
      slope_gate_lower_end_out <= v[0];
   endtask : set_ends

   // counts and mode chosen per line by the caller
   // smode: 0 shutter unused, 1 shutter used, 2 held closed
   task automatic run_line(input int integ, input int pulses,
      input int smode, input bit pinned, input bit slope);
      tick(1);
      overflow_reset_gate_out <= (smode != 0);
      tick(3);
      // reset gate low whole line when shutter unused
      overflow_reset_gate_out <= (smode == 2);
      // fixed slope, or both ends pinned alike
      set_ends(pinned ? 2'b00 : 2'b10);
      tick(integ - 4);
      // slope formed ahead of transfer gate
      if (pinned && slope) set_ends(2'b10);
      tick(4);
      // transfer high, phase one high, transfer low
      store_to_shift_gate_out <= 1'b1;
      tick(3);
      shift_phase_one_out <= 1'b1;
      tick(3);
      store_to_shift_gate_out <= 1'b0;
      tick(3);
      shift_phase_one_out <= 1'b0;
      if (pinned) set_ends(2'b00);
      tick(3);
      reading_out <= 1'b1;
      // each phase level held three cycles
      repeat (pulses) begin
         shift_phase_two_out <= 1'b1;
         tick(3);
         shift_phase_two_out <= 1'b0;
         tick(3);
         shift_phase_one_out <= 1'b1;
         tick(3);
         shift_phase_one_out <= 1'b0;
         tick(3);
      end
      tick(6);
      reading_out <= 1'b0;
      overflow_reset_gate_out <= 1'b0;
   endtask : run_line
endmodule : ccd_gate_gen
`default_nettype wire

// ===== linear_ccd_gate_sequencer_bench.sv
// self-checking bench for the gate-driven sensor charge model
// assumes rg_ccd_pkg, rg_ccd_sensor and the ccd_gate_gen model
`timescale 1ns/100ps
`default_nettype none
module linear_ccd_gate_sequencer_bench;
   import rg_ccd_pkg::*;
   localparam int PIX = 4;
   // full well plus six transfer-gate cycles of photo charge
   localparam logic [CHARGE_W-1:0] FULL_LINE = 16'h0100 + 6 * 16'h0080;
   logic sys_clk_in, sys_rst_in, pix_clk;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, vvalid;
   logic [1:0] bresp, rresp;
   logic [CHARGE_W-1:0] video;
   wire logic g_rst, g_xfer, g_p1, g_p2, g_up, g_lo, reading;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [CHARGE_W-1:0] pix_q[$];

   rg_ccd_sensor #(.PIXELS(PIX)) u_dut (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .pix_clk_in(pix_clk),
      .overflow_reset_gate_in(g_rst), .store_to_shift_gate_in(g_xfer),
      .shift_phase_one_in(g_p1), .shift_phase_two_in(g_p2),
      .slope_gate_upper_end_in(g_up), .slope_gate_lower_end_in(g_lo),
      .video_output_out(video), .video_valid_out(vvalid),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready));

   ccd_gate_gen u_gen (.pix_clk_in(pix_clk),
      .overflow_reset_gate_out(g_rst), .store_to_shift_gate_out(g_xfer),
      .shift_phase_one_out(g_p1), .shift_phase_two_out(g_p2),
      .slope_gate_upper_end_out(g_up), .slope_gate_lower_end_out(g_lo),
      .reading_out(reading));

   initial begin
      sys_clk_in = 1'b0;
      forever #10 sys_clk_in = ~sys_clk_in;
   end
   // free-running: the charge model integrates on every link cycle
   initial begin
      pix_clk = 1'b0;
      #7;
      forever #40 pix_clk = ~pix_clk;
   end

   always @(posedge pix_clk)
      if (reading === 1'b1 && vvalid === 1'b1) pix_q.push_back(video);

   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   task automatic axi_wr(input string what, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [1:0] er);
      bit b = 1'b0;
      @(posedge sys_clk_in);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge sys_clk_in);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            b = 1'b1;
            check(what, 32'(bresp), 32'(er));
            bready <= 1'b0;
         end
      end
   endtask : axi_wr

   task automatic axi_rd(input string what, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] ed, input logic [1:0] er);
      bit b = 1'b0;
      @(posedge sys_clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!b) begin
         @(posedge sys_clk_in);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            b = 1'b1;
            check(what, rdata, ed);
            check(what, 32'(rresp), 32'(er));
            rready <= 1'b0;
         end
      end
   endtask : axi_rd

   // pixels beyond the array length read back as zero
   task automatic line(input int integ, input int pulses, input int smode,
      input bit pinned, input bit slope, input logic [CHARGE_W-1:0] exp);
      pix_q.delete();
      u_gen.run_line(integ, pulses, smode, pinned, slope);
      check("pixel count", 32'(pix_q.size()), 32'(pulses));
      foreach (pix_q[i])
         check("pixel", 32'(pix_q[i]), (i < PIX) ? 32'(exp) : 32'h0);
   endtask : line

   initial begin
      sys_rst_in = 1'b1;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      // link side needs its own reset edges too
      repeat (6) @(posedge pix_clk);
      @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      repeat (6) @(posedge pix_clk);
      axi_rd("rate rst", ADDR_PHOTO_RATE, 32'(PHOTO_RATE_RST), RESP_OKAY);
      axi_rd("well rst", ADDR_FULL_WELL, 32'(FULL_WELL_RST), RESP_OKAY);
      axi_rd("lines rst", ADDR_LINES, 32'h0, RESP_OKAY);
      axi_rd("unmapped", 8'h18, 32'h0, RESP_SLVERR);
      axi_wr("ro write", ADDR_INTEG, 32'h5, RESP_SLVERR);
      axi_wr("well wr", ADDR_FULL_WELL, 32'h0100, RESP_OKAY);
      axi_wr("rate wr", ADDR_PHOTO_RATE, 32'h0080, RESP_OKAY);
      axi_rd("well back", ADDR_FULL_WELL, 32'h0100, RESP_OKAY);
      repeat (8) @(posedge pix_clk);
      line(20, PIX + 2, 1, 1'b0, 1'b0, FULL_LINE);
      axi_rd("integ", ADDR_INTEG, 32'd26, RESP_OKAY);
      line(20, PIX, 2, 1'b0, 1'b0, 16'h0000);
      line(20, 0, 0, 1'b0, 1'b0, 16'h0000);
      line(20, PIX, 0, 1'b0, 1'b0, FULL_LINE);
      line(20, PIX, 1, 1'b1, 1'b0, 16'h0000);
      line(20, PIX, 1, 1'b1, 1'b1, FULL_LINE);
      axi_rd("lines", ADDR_LINES, 32'd6, RESP_OKAY);
      summarize();
   end
endmodule : linear_ccd_gate_sequencer_bench
`default_nettype wire
